// *** design/tap_defs.svh ***
// Constant macros for the boundary-scan port and its controller.
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH

// Register lengths.
`define IR_LEN 3
`define ID_LEN 32
`define BSR_LEN 109
`define BSR_CNT_W 7
`define OE_CELL 108

// Instruction codes.
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLEZ 3'h2
`define IR_PRELOAD 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE 3'h1

// Identification word fields; the type and vendor values are arbitrary.
`define ID_REVISION 3'h0
`define ID_DEVTYPE 17'h0a5a5
`define ID_VENDOR 11'h2aa
`define ID_WORD {`ID_REVISION, `ID_DEVTYPE, `ID_VENDOR, 1'b1}

// Power-up value of the parallel latches: the output-enable cell is preset.
`define UPD_RESET {1'b1, 108'h0}

// Reset walk and scan framing lengths, in test-clock periods.
`define RESET_TMS_HIGH 7'h5
`define HEAD_LAST_IR 7'h3
`define HEAD_LAST_DR 7'h2
`define TAIL_LAST 7'h1

// Link clock timing.
`define CLK_PERIOD_NS 5
`define TCK_MIN_PERIOD_NS 50
`define TCK_HALF_CYC ((`TCK_MIN_PERIOD_NS + 2 * `CLK_PERIOD_NS - 1) / (2 * `CLK_PERIOD_NS))
`define HALF_CNT_W 4

`endif

// *** design/tap_pkg.sv ***
// Types shared by the boundary-scan port and its controller.
package tap_pkg;

  // Standard sixteen-state test controller, one-hot.
  typedef enum logic [15:0] {
    S_TLR = 16'h0001,
    S_RTI = 16'h0002,
    S_SELDR = 16'h0004,
    S_CAPDR = 16'h0008,
    S_SHDR = 16'h0010,
    S_EX1DR = 16'h0020,
    S_PAUSEDR = 16'h0040,
    S_EX2DR = 16'h0080,
    S_UPDR = 16'h0100,
    S_SELIR = 16'h0200,
    S_CAPIR = 16'h0400,
    S_SHIR = 16'h0800,
    S_EX1IR = 16'h1000,
    S_PAUSEIR = 16'h2000,
    S_EX2IR = 16'h4000,
    S_UPIR = 16'h8000
  } tap_state_t;

  // Sequencer states of the driving controller, one-hot.
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_RESET = 5'h02,
    H_HEAD = 5'h04,
    H_SHIFT = 5'h08,
    H_TAIL = 5'h10
  } host_state_t;

endpackage

// *** design/tap_if.sv ***
// Serial test link between the controller and the scan port.
`timescale 1ns/1ps
interface tap_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  logic tdo_line;

  // The data-out wire floats high through its pull-up when undriven.
  assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

  modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
  modport ctl (output tck, output tms, output tdi, input tdo_line);
endinterface

// *** design/tap_port.sv ***
// Boundary-scan test port of the memory, clocked by the link's test clock.
`timescale 1ns/1ps
`include "tap_defs.svh"
module tap_port
  import tap_pkg::*;
(
  // Control
  input wire logic rst_i,
  input wire logic ce_i,
  // Serial test link
  tap_if.dev link,
  // Memory pin ring
  input wire logic [`BSR_LEN-1:0] pins_i,
  output logic [`BSR_LEN-1:0] drive_val_o,
  output logic drive_en_o,
  output logic q_oe_o
);

  tap_state_t st;
  tap_state_t next_st;
  logic [`IR_LEN-1:0] ir;
  logic [`IR_LEN-1:0] ir_sr;
  logic bypass;
  logic [`ID_LEN-1:0] id_sr;
  logic [`BSR_LEN-1:0] bsr;
  logic [`BSR_LEN-1:0] upd;
  logic [`BSR_LEN-1:0] pins_meta;
  logic [`BSR_LEN-1:0] pins_sync;
  logic tdo_q;
  logic tdo_oe_n_q;

  // State decodes.
  wire in_tlr = (st == S_TLR);
  wire in_capdr = (st == S_CAPDR);
  wire in_shdr = (st == S_SHDR);
  wire in_updr = (st == S_UPDR);
  wire in_capir = (st == S_CAPIR);
  wire in_shir = (st == S_SHIR);
  wire in_upir = (st == S_UPIR);

  // Instruction decodes; a reserved code falls back to the bypass bit.
  wire is_extest = (ir == `IR_EXTEST);
  wire is_samplez = (ir == `IR_SAMPLEZ);
  wire is_preload = (ir == `IR_PRELOAD);
  wire sel_id = (ir == `IR_IDCODE);
  wire sel_bsr = is_extest | is_samplez | is_preload;
  wire sel_byp = !sel_id && !sel_bsr;

  // Value the instruction register will hold after this edge.
  wire [`IR_LEN-1:0] next_ir = in_tlr ? `IR_IDCODE : (in_upir ? ir_sr : ir);

  // Value the output-enable latch will hold after this edge.
  wire next_oe_cell = in_tlr ? 1'b1 : ((in_updr && sel_bsr) ? bsr[`OE_CELL] : upd[`OE_CELL]);

  // Output bus enable: floated under sample-with-float, gated by the cell in test.
  wire next_q_oe = (next_ir == `IR_SAMPLEZ) ? 1'b0 :
                   ((next_ir == `IR_EXTEST) ? next_oe_cell : 1'b1);

  // Bit presented on data-out in the coming low half of the test clock.
  wire dr_lsb = sel_id ? id_sr[0] : (sel_bsr ? bsr[0] : bypass);
  wire next_tdo = in_shir ? ir_sr[0] : dr_lsb;

  // Controller next state from mode select.
  always_comb begin
    case (st)
      S_TLR: next_st = link.tms ? S_TLR : S_RTI;
      S_RTI: next_st = link.tms ? S_SELDR : S_RTI;
      S_SELDR: next_st = link.tms ? S_SELIR : S_CAPDR;
      S_CAPDR: next_st = link.tms ? S_EX1DR : S_SHDR;
      S_SHDR: next_st = link.tms ? S_EX1DR : S_SHDR;
      S_EX1DR: next_st = link.tms ? S_UPDR : S_PAUSEDR;
      S_PAUSEDR: next_st = link.tms ? S_EX2DR : S_PAUSEDR;
      S_EX2DR: next_st = link.tms ? S_UPDR : S_SHDR;
      S_UPDR: next_st = link.tms ? S_SELDR : S_RTI;
      S_SELIR: next_st = link.tms ? S_TLR : S_CAPIR;
      S_CAPIR: next_st = link.tms ? S_EX1IR : S_SHIR;
      S_SHIR: next_st = link.tms ? S_EX1IR : S_SHIR;
      S_EX1IR: next_st = link.tms ? S_UPIR : S_PAUSEIR;
      S_PAUSEIR: next_st = link.tms ? S_EX2IR : S_PAUSEIR;
      S_EX2IR: next_st = link.tms ? S_UPIR : S_SHIR;
      S_UPIR: next_st = link.tms ? S_SELDR : S_RTI;
      default: next_st = S_TLR;
    endcase
  end

  // Controller state. Any state reaches the reset state within five
  // mode-high edges, and memory traffic never looks at this logic.
  always_ff @(posedge link.tck) begin
    if (rst_i) begin
      st <= S_TLR;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // Pin ring crosses from the memory clock; two flops before capture.
  // Values that move during capture may still be caught mid-transition,
  // so a user must hold pins steady to get repeatable snapshots.
  always_ff @(posedge link.tck) begin
    if (rst_i) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else if (ce_i) begin
      pins_meta <= pins_i;
      pins_sync <= pins_meta;
    end
  end

  // Instruction shift register: fixed pattern on capture, serial on shift.
  always_ff @(posedge link.tck) begin
    if (rst_i) begin
      ir_sr <= `IR_IDCODE;
    end else if (ce_i) begin
      if (in_capir) begin
        ir_sr <= `IR_CAPTURE;
      end else if (in_shir) begin
        ir_sr <= {link.tdi, ir_sr[`IR_LEN-1:1]};
      end
    end
  end

  // Current instruction; changes only at instruction update or reset state.
  always_ff @(posedge link.tck) begin
    if (rst_i) begin
      ir <= `IR_IDCODE;
    end else if (ce_i) begin
      ir <= next_ir;
    end
  end

  // Bypass bit: zero on capture, one stage of delay on shift.
  always_ff @(posedge link.tck) begin
    if (rst_i) begin
      bypass <= 1'b0;
    end else if (ce_i && sel_byp) begin
      if (in_capdr) begin
        bypass <= 1'b0;
      end else if (in_shdr) begin
        bypass <= link.tdi;
      end
    end
  end

  // Identification register: hardwired word on capture, shifted out after.
  always_ff @(posedge link.tck) begin
    if (rst_i) begin
      id_sr <= `ID_WORD;
    end else if (ce_i && sel_id) begin
      if (in_capdr) begin
        id_sr <= `ID_WORD;
      end else if (in_shdr) begin
        id_sr <= {link.tdi, id_sr[`ID_LEN-1:1]};
      end
    end
  end

  // Boundary chain: pin snapshot on capture, serial on shift. New preload
  // data enters the top while the snapshot leaves the bottom.
  always_ff @(posedge link.tck) begin
    if (rst_i) begin
      bsr <= '0;
    end else if (ce_i && sel_bsr) begin
      if (in_capdr) begin
        bsr <= pins_sync;
      end else if (in_shdr) begin
        bsr <= {link.tdi, bsr[`BSR_LEN-1:1]};
      end
    end
  end

  // Parallel latches: loaded at data update, enable cell preset in reset.
  always_ff @(posedge link.tck) begin
    if (rst_i) begin
      upd <= `UPD_RESET;
    end else if (ce_i) begin
      if (in_tlr) begin
        upd[`OE_CELL] <= 1'b1;
      end else if (in_updr && sel_bsr) begin
        upd <= bsr;
      end
    end
  end

  // Pin-side outputs follow the next instruction so they stay flop-driven
  // and still change on the same edge as the instruction.
  always_ff @(posedge link.tck) begin
    if (rst_i) begin
      drive_en_o <= 1'b0;
      q_oe_o <= 1'b1;
    end else if (ce_i) begin
      drive_en_o <= (next_ir == `IR_EXTEST);
      q_oe_o <= next_q_oe;
    end
  end

  // Drive values are the latches themselves.
  assign drive_val_o = upd;

  // Data-out changes on the falling edge and is driven only while shifting,
  // which gives the controller a full half period of setup.
  always_ff @(negedge link.tck) begin
    if (rst_i) begin
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else if (ce_i) begin
      tdo_q <= next_tdo;
      tdo_oe_n_q <= !(in_shir || in_shdr);
    end
  end

  assign link.tdo = tdo_q;
  assign link.tdo_oe_n = tdo_oe_n_q;

endmodule

// *** design/tap_master.sv ***
// Test controller that makes the link clock and runs register scans.
`timescale 1ns/1ps
`include "tap_defs.svh"
module tap_master
  import tap_pkg::*;
(
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Scan requests
  input wire logic start_i,
  input wire logic reset_req_i,
  input wire logic is_ir_i,
  input wire logic [`BSR_CNT_W-1:0] len_i,
  input wire logic [`BSR_LEN-1:0] data_i,
  output logic busy_o,
  output logic done_o,
  output logic [`BSR_LEN-1:0] data_o,
  // Serial test link
  tap_if.ctl link
);

  localparam logic [`HALF_CNT_W-1:0] HALF_LAST = `HALF_CNT_W'(`TCK_HALF_CYC - 1);

  host_state_t st;
  logic [`HALF_CNT_W-1:0] hc;
  logic [`BSR_CNT_W-1:0] cnt;
  logic [`BSR_CNT_W-1:0] len_q;
  logic ir_q;
  logic tck_q;
  logic tms_q;
  logic tdi_q;
  logic tdo_meta;
  logic tdo_sync;
  logic [`BSR_LEN-1:0] sreg;
  logic [`BSR_LEN-1:0] next_sreg;
  logic [`BSR_LEN:0] sreg_ext;

  // Half-period ticks of the derived test clock.
  wire tick = busy_o && (hc == HALF_LAST);
  wire rise = tick && !tck_q;
  wire fall = tick && tck_q;
  wire idle_start = !busy_o && (start_i || reset_req_i);
  wire [`BSR_CNT_W-1:0] last_bit = len_q - `BSR_CNT_W'(1);
  wire [`BSR_CNT_W-1:0] head_last = ir_q ? `HEAD_LAST_IR : `HEAD_LAST_DR;

  // Mode select for the bit after the current one: the reset walk holds it
  // high for five edges, the head walks to the shift state, the tail updates.
  wire nxt_tms = (st == H_RESET) ? (cnt < `RESET_TMS_HIGH) :
                 (st == H_HEAD) ? ((cnt == 7'h0) || (ir_q && cnt == 7'h1)) :
                 (st == H_SHIFT) ? (cnt == last_bit) :
                 (cnt == 7'h0);
  wire nxt_tdi = (st == H_SHIFT) ? sreg[0] : 1'b0;

  // Capture shift: each returned bit enters at the top of the live length.
  assign sreg_ext = {1'b0, sreg};
  generate
    for (genvar gi = 0; gi < `BSR_LEN; gi++) begin : g_cap
      localparam logic [`BSR_CNT_W-1:0] IDX = `BSR_CNT_W'(gi);
      assign next_sreg[gi] = (IDX == last_bit) ? tdo_sync :
                             ((IDX < last_bit) ? sreg_ext[gi+1] : 1'b0);
    end
  endgenerate

  // Data-out arrives from the far end's domain; two flops before use.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdo_meta <= 1'b1;
      tdo_sync <= 1'b1;
    end else if (ce_i) begin
      tdo_meta <= link.tdo_line;
      tdo_sync <= tdo_meta;
    end
  end

  // Clock divider; the link clock stops low between scans.
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      hc <= '0;
      tck_q <= 1'b0;
    end else if (ce_i) begin
      hc <= tick ? '0 : hc + `HALF_CNT_W'(1);
      tck_q <= tick ? !tck_q : tck_q;
    end
  end

  // Sequencer: advances on each rising link edge, sets up on falling ones.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= H_IDLE;
      cnt <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      tms_q <= 1'b1;
      tdi_q <= 1'b0;
      ir_q <= 1'b0;
      len_q <= '0;
      sreg <= '0;
      data_o <= '0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (idle_start) begin
        st <= reset_req_i ? H_RESET : H_HEAD;
        cnt <= '0;
        busy_o <= 1'b1;
        tms_q <= 1'b1;
        tdi_q <= 1'b0;
        ir_q <= is_ir_i;
        len_q <= len_i;
        sreg <= data_i;
      end else if (rise) begin
        cnt <= cnt + `BSR_CNT_W'(1);
        case (st)
          H_RESET: begin
            if (cnt == `RESET_TMS_HIGH) begin
              st <= H_IDLE;
            end
          end
          H_HEAD: begin
            if (cnt == head_last) begin
              st <= H_SHIFT;
              cnt <= '0;
            end
          end
          H_SHIFT: begin
            sreg <= next_sreg;
            if (cnt == last_bit) begin
              st <= H_TAIL;
              cnt <= '0;
            end
          end
          H_TAIL: begin
            if (cnt == `TAIL_LAST) begin
              st <= H_IDLE;
            end
          end
          default: st <= H_IDLE;
        endcase
      end else if (fall) begin
        if (st == H_IDLE) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          data_o <= sreg;
          tms_q <= 1'b1;
          tdi_q <= 1'b0;
        end else begin
          tms_q <= nxt_tms;
          tdi_q <= nxt_tdi;
        end
      end
    end
  end

  assign link.tck = tck_q;
  assign link.tms = tms_q;
  assign link.tdi = tdi_q;

endmodule

// *** tb/tap_link_assertions.sv ***
// Concurrent checks on the serial test link between controller and scan port.
`timescale 1ns/1ps
module tap_link_checker (
  // Controller clock domain
  input wire logic clk_i,
  input wire logic rst_i,
  // Scan port reset, which also covers its link logic
  input wire logic dev_rst_i,
  // Serial test link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  // Five mode-high edges park the port in reset, whatever state it was in.
  sequence reset_walk;
    tms [*5];
  endsequence
  // From reset: idle, select, capture, then shift of the data path.
  sequence to_data_shift;
    reset_walk ##1 !tms ##1 tms ##1 !tms [*2];
  endsequence
  // The instruction path takes one more select step.
  sequence to_instr_shift;
    reset_walk ##1 !tms ##1 tms [*2] ##1 !tms [*2];
  endsequence

  // The port output may only move at a falling link clock edge.
  a_tdo_on_fall: assert property (@(posedge clk_i) disable iff (dev_rst_i)
    !$fell(tck) |-> $stable(tdo) && $stable(tdo_oe_n)) else $error("data out moved late");
  // Mode and data stay put while the link clock is high.
  a_ctl_hold_high: assert property (@(posedge clk_i) disable iff (rst_i)
    tck |-> $stable(tms) && $stable(tdi)) else $error("mode or data moved in high phase");
  a_tck_high_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tck) |-> tck [*5] ##1 !tck) else $error("link clock high phase wrong");
  a_tck_low_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(tck) |-> !tck [*5]) else $error("link clock low phase short");
  // No state reached with mode high is a shift state.
  a_exit_quiet: assert property (@(posedge tck) disable iff (dev_rst_i)
    tms |=> tdo_oe_n) else $error("data out driven outside shift");
  a_shift_holds: assert property (@(posedge tck) disable iff (dev_rst_i)
    !tdo_oe_n && !tms |=> !tdo_oe_n) else $error("data out released in shift");
  // After reset the identification word leads with its constant one.
  a_dr_first_bit: assert property (@(posedge tck) disable iff (dev_rst_i)
    to_data_shift |=> !tdo_oe_n && tdo) else $error("first data bit wrong");
  // Instruction capture puts a one in the lowest bit.
  a_ir_first_bit: assert property (@(posedge tck) disable iff (dev_rst_i)
    to_instr_shift |=> !tdo_oe_n && tdo) else $error("first instruction bit wrong");
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench: the controller and the scan port joined over the test link.
`timescale 1ns/1ps
`include "tap_defs.svh"
module tb_top;
  import tap_pkg::*;

  typedef struct packed {
    logic rw;
    logic ir;
    logic [`BSR_CNT_W-1:0] len;
    logic [`BSR_LEN-1:0] din;
    logic [`BSR_LEN-1:0] dexp;
    logic en;
    logic oe;
  } row_t;

  // Pin ring and two preload patterns; the top cell is low in both.
  localparam logic [`BSR_LEN-1:0] PINS = {1'h0, {27{4'ha}}};
  localparam logic [`BSR_LEN-1:0] DPAT = {1'h0, {27{4'h3}}};
  localparam logic [`BSR_LEN-1:0] EPAT = {1'h0, {27{4'hc}}};
  localparam logic [`BSR_LEN-1:0] IDW = {77'h0, `ID_REVISION, `ID_DEVTYPE, `ID_VENDOR, 1'h1};
  localparam logic [`BSR_LEN-1:0] CAPIR = {106'h0, 3'h1};

  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic dev_rst = 1'h1;
  logic start_i = 1'h0;
  logic reset_req_i = 1'h0;
  logic is_ir_i = 1'h0;
  logic [`BSR_CNT_W-1:0] len_i = '0;
  logic [`BSR_LEN-1:0] data_i = '0;
  logic busy_o;
  logic done_o;
  logic [`BSR_LEN-1:0] data_o;
  logic [`BSR_LEN-1:0] drive_val_o;
  logic drive_en_o;
  logic q_oe_o;
  int mismatches = 0;
  int num_checks = 0;
  row_t rows [14];

  tap_if link ();

  tap_master tap_master_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .start_i(start_i),
    .reset_req_i(reset_req_i), .is_ir_i(is_ir_i), .len_i(len_i), .data_i(data_i),
    .busy_o(busy_o), .done_o(done_o), .data_o(data_o), .link(link));
  tap_port tap_port_inst (.rst_i(dev_rst), .ce_i(1'h1), .link(link), .pins_i(PINS),
    .drive_val_o(drive_val_o), .drive_en_o(drive_en_o), .q_oe_o(q_oe_o));
  tap_link_checker tap_link_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .dev_rst_i(dev_rst),
    .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe_n(link.tdo_oe_n));

  // Controller clock; the link clock is divided down from it.
  always #2.5 clk_i = ~clk_i;

  task automatic check(input string what, input logic [`BSR_LEN-1:0] exp,
                       input logic [`BSR_LEN-1:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Start is held one cycle into busy on purpose, so a refused request is exercised.
  task automatic run(input row_t r);
    int n;
    reset_req_i <= r.rw;
    start_i <= !r.rw;
    is_ir_i <= r.ir;
    len_i <= r.len;
    data_i <= r.din;
    repeat (2) @(posedge clk_i);
    start_i <= 1'h0;
    reset_req_i <= 1'h0;
    for (n = 0; n < 2000 && done_o !== 1'h1; n++) @(posedge clk_i);
    check("done_o", 1'h1, done_o);
    @(posedge clk_i);
    check("busy_o", '0, busy_o);
    check("done_o", '0, done_o);
  endtask

  task automatic do_row(input row_t r);
    run(r);
    if (!r.rw) check("data_o", r.dexp, data_o);
    check("drive_en_o", r.en, drive_en_o);
    check("q_oe_o", r.oe, q_oe_o);
  endtask

  // Main sequence: table of scans, then the reset cases by hand.
  initial begin
    rows[0] = '{1'h1, 1'h0, 7'h00, '0, '0, 1'h0, 1'h1};
    rows[1] = '{1'h0, 1'h0, 7'h20, '0, IDW, 1'h0, 1'h1};
    // Only the five defined codes are ever loaded; reserved ones stay unused.
    rows[2] = '{1'h0, 1'h1, 7'h03, 109'h7, CAPIR, 1'h0, 1'h1};
    rows[3] = '{1'h0, 1'h0, 7'h04, 109'hb, 109'h6, 1'h0, 1'h1};
    rows[4] = '{1'h0, 1'h1, 7'h03, 109'h4, CAPIR, 1'h0, 1'h1};
    rows[5] = '{1'h0, 1'h0, 7'h6d, DPAT, PINS, 1'h0, 1'h1};
    rows[6] = '{1'h0, 1'h1, 7'h03, 109'h0, CAPIR, 1'h1, 1'h0};
    rows[7] = '{1'h0, 1'h1, 7'h03, 109'h2, CAPIR, 1'h0, 1'h0};
    rows[8] = '{1'h0, 1'h0, 7'h6d, EPAT, PINS, 1'h0, 1'h0};
    rows[9] = '{1'h0, 1'h1, 7'h03, 109'h7, CAPIR, 1'h0, 1'h1};
    rows[10] = rows[0];
    rows[11] = rows[1];
    rows[12] = rows[0];
    rows[13] = rows[9];
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    // The port reset is synchronous to the link clock, so a walk clocks it.
    run(rows[0]);
    dev_rst <= 1'h0;
    foreach (rows[i]) do_row(rows[i]);
    check("drive_val_o", {1'h1, EPAT[107:0]}, drive_val_o);
    dev_rst <= 1'h1;
    run(rows[0]);
    dev_rst <= 1'h0;
    do_row(rows[0]);
    check("drive_val_o", `UPD_RESET, drive_val_o);
    check("tdo_oe_n", 1'h1, link.tdo_oe_n);
    check("tdo_line", 1'h1, link.tdo_line);
    do_row(rows[1]);
    // External test with the enable cell still preset drives the bus, then a
    // chain load updated under external test clears the cell and floats it.
    rows[13] = '{1'h0, 1'h1, 7'h03, 109'h0, CAPIR, 1'h1, 1'h1};
    do_row(rows[13]);
    rows[13] = '{1'h0, 1'h0, 7'h6d, DPAT, PINS, 1'h1, 1'h0};
    do_row(rows[13]);
    check("drive_val_o", DPAT, drive_val_o);
    tally_and_finish();
  end

  // Watchdog well beyond the length of all scans together.
  initial begin
    #300000;
    mismatches++;
    tally_and_finish();
  end
endmodule
